// >>> verilog/bmu_pkg.sv
// constants, op codes and carrier types of the bit-manipulation unit
// Behaviour
// - set, clear, invert, test take bit number from immediate or register low three bits
// - inverse carry operations take bit number from the immediate field only
// - bit set forces selected operand bit to one and writes the byte back
// - bit clear forces selected operand bit to zero and writes the byte back
// - bit invert complements selected operand bit and writes the byte back
// - bit test loads zero flag with complement of selected bit, operand unchanged
// - carry-AND: carry becomes carry AND selected bit
// - carry-AND-inverse: carry becomes carry AND inverted selected bit
// - carry-OR: carry becomes carry OR selected bit
// - carry-OR-inverse: carry becomes carry OR inverted selected bit
// - carry-XOR: carry becomes carry XOR selected bit
// - carry-XOR-inverse: carry becomes carry XOR inverted selected bit
// - bit load copies selected bit into carry
// - inverted bit load copies inverted selected bit into carry
// - bit store writes carry into selected bit
// - inverted bit store writes inverted carry into selected bit
package bmu_pkg;

  localparam int unsigned BMU_DATA_W = 8;
  localparam int unsigned BMU_IDX_W  = 3;
  localparam int unsigned BMU_OP_W   = 4;

  // operation select from the instruction decoder
  typedef enum logic [BMU_OP_W-1:0] {
    BMU_BIT_SET_OP            = 4'h0,
    BMU_BIT_CLEAR_OP          = 4'h1,
    BMU_BIT_INVERT_OP         = 4'h2,
    BMU_BIT_TEST_OP           = 4'h3,
    BMU_CARRY_AND_BIT_OP      = 4'h4,
    BMU_CARRY_AND_INV_BIT_OP  = 4'h5,
    BMU_CARRY_OR_BIT_OP       = 4'h6,
    BMU_CARRY_OR_INV_BIT_OP   = 4'h7,
    BMU_CARRY_XOR_BIT_OP      = 4'h8,
    BMU_CARRY_XOR_INV_BIT_OP  = 4'h9,
    BMU_BIT_TO_CARRY_OP       = 4'ha,
    BMU_INV_BIT_TO_CARRY_OP   = 4'hb,
    BMU_CARRY_TO_BIT_OP       = 4'hc,
    BMU_INV_CARRY_TO_BIT_OP   = 4'hd
  } bmu_op_type;

  typedef struct packed {
    logic                  valid;
    bmu_op_type            op;
    logic                  idx_from_reg;
    logic [BMU_IDX_W-1:0]  imm_idx;
    logic [BMU_DATA_W-1:0] idx_reg;
    logic [BMU_DATA_W-1:0] operand;
    logic                  carry_in;
  } bmu_req_type;

  typedef struct packed {
    logic                  done;
    logic                  write_en;
    logic [BMU_DATA_W-1:0] result;
    logic                  carry_we;
    logic                  carry_out;
    logic                  zero_we;
    logic                  zero_out;
    logic                  illegal;
  } bmu_rsp_type;

  localparam bmu_rsp_type BMU_RSP_RST = '0;

endpackage : bmu_pkg

// >>> verilog/bmu_core.sv
// bit-manipulation datapath: one registered result per request
`timescale 1ns/100ps
module bmu_core
  import bmu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire bmu_req_type req,
  output      bmu_rsp_type rsp
);

  typedef struct packed {
    bmu_rsp_type rsp;
  } bmu_state_type;

  bmu_state_type st_q;
  bmu_state_type st_d;

  logic [BMU_IDX_W-1:0]  sel;
  logic                  inv_op;
  logic                  bit_v;
  logic [BMU_DATA_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // inverse-carry forms carry no register field, so a register select is refused
  assign inv_op = (req.op == BMU_CARRY_AND_INV_BIT_OP) || (req.op == BMU_CARRY_OR_INV_BIT_OP)
               || (req.op == BMU_CARRY_XOR_INV_BIT_OP) || (req.op == BMU_INV_BIT_TO_CARRY_OP)
               || (req.op == BMU_INV_CARRY_TO_BIT_OP);

  // register low three bits only; upper bits ignored
  assign sel = req.idx_from_reg ? req.idx_reg[BMU_IDX_W-1:0] : req.imm_idx;

  generate
    for (genvar i = 0; i < BMU_DATA_W; i++)
    begin : g_mask
      assign mask[i] = (sel == BMU_IDX_W'(i));
    end
  endgenerate

  assign bit_v = req.operand[sel];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d             = '0;
    st_d.rsp.result  = req.operand;
    st_d.rsp.done    = req.valid;
    if (req.valid && inv_op && req.idx_from_reg)
    begin
      st_d.rsp.illegal = 1'h1;
    end
    else if (req.valid)
    begin
      case (req.op)
        BMU_BIT_SET_OP:
        begin
          st_d.rsp.result   = req.operand | mask;
          st_d.rsp.write_en = 1'h1;
        end
        BMU_BIT_CLEAR_OP:
        begin
          st_d.rsp.result   = req.operand & ~mask;
          st_d.rsp.write_en = 1'h1;
        end
        BMU_BIT_INVERT_OP:
        begin
          st_d.rsp.result   = req.operand ^ mask;
          st_d.rsp.write_en = 1'h1;
        end
        BMU_BIT_TEST_OP:
        begin
          st_d.rsp.zero_we  = 1'h1;
          st_d.rsp.zero_out = ~bit_v;
        end
        BMU_CARRY_AND_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in & bit_v;
        end
        BMU_CARRY_AND_INV_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in & ~bit_v;
        end
        BMU_CARRY_OR_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in | bit_v;
        end
        BMU_CARRY_OR_INV_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in | ~bit_v;
        end
        BMU_CARRY_XOR_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in ^ bit_v;
        end
        BMU_CARRY_XOR_INV_BIT_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = req.carry_in ^ ~bit_v;
        end
        BMU_BIT_TO_CARRY_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = bit_v;
        end
        BMU_INV_BIT_TO_CARRY_OP:
        begin
          st_d.rsp.carry_we  = 1'h1;
          st_d.rsp.carry_out = ~bit_v;
        end
        BMU_CARRY_TO_BIT_OP:
        begin
          st_d.rsp.result   = (req.operand & ~mask) | (req.carry_in ? mask : '0);
          st_d.rsp.write_en = 1'h1;
        end
        BMU_INV_CARRY_TO_BIT_OP:
        begin
          st_d.rsp.result   = (req.operand & ~mask) | (req.carry_in ? '0 : mask);
          st_d.rsp.write_en = 1'h1;
        end
        default:
        begin
          st_d.rsp.illegal = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q.rsp <= BMU_RSP_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rsp = st_q.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_set_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_SET_OP)
      |=> (rsp.write_en && rsp.result == ($past(req.operand) | $past(mask)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

  property p_clear_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_CLEAR_OP)
      |=> (rsp.result[$past(sel)] == 1'h0 && rsp.write_en);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong");

  property p_invert_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_INVERT_OP)
      |=> (rsp.result[$past(sel)] != $past(bit_v));
  endproperty
  a_invert_bit: assert property (p_invert_bit) else $error("bit invert wrong");

  property p_test_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_TEST_OP)
      |=> (rsp.zero_we && rsp.zero_out == !$past(bit_v) && !rsp.write_en);
  endproperty
  a_test_bit: assert property (p_test_bit) else $error("bit test wrong");

  property p_reg_index;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_TEST_OP && req.idx_from_reg)
      |=> (rsp.zero_out == !$past(req.operand[req.idx_reg[BMU_IDX_W-1:0]]));
  endproperty
  a_reg_index: assert property (p_reg_index) else $error("register index wrong");

  property p_inv_reg_refused;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && inv_op && req.idx_from_reg)
      |=> (rsp.illegal && !rsp.carry_we && !rsp.write_en);
  endproperty
  a_inv_reg_refused: assert property (p_inv_reg_refused) else $error("inverse op took reg");

  property p_carry_and;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_CARRY_AND_BIT_OP)
      |=> (rsp.carry_we && rsp.carry_out == ($past(req.carry_in) & $past(bit_v)));
  endproperty
  a_carry_and: assert property (p_carry_and) else $error("carry and wrong");

  property p_carry_xor_inv;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_CARRY_XOR_INV_BIT_OP && !req.idx_from_reg)
      |=> (rsp.carry_out == ($past(req.carry_in) ^ !$past(bit_v)));
  endproperty
  a_carry_xor_inv: assert property (p_carry_xor_inv) else $error("carry xor inv wrong");

  property p_store_carry;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_CARRY_TO_BIT_OP)
      |=> (rsp.result[$past(sel)] == $past(req.carry_in));
  endproperty
  a_store_carry: assert property (p_store_carry) else $error("carry store wrong");

  property p_load_bit;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_BIT_TO_CARRY_OP)
      |=> (rsp.carry_we && rsp.carry_out == $past(bit_v) && !rsp.write_en);
  endproperty
  a_load_bit: assert property (p_load_bit) else $error("bit load wrong");

  property p_store_inv_carry;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && req.op == BMU_INV_CARRY_TO_BIT_OP && !req.idx_from_reg)
      |=> (rsp.write_en && rsp.result[$past(sel)] == !$past(req.carry_in));
  endproperty
  a_store_inv_carry: assert property (p_store_inv_carry) else $error("inv store wrong");

  property p_keep_others;
    @(posedge clk_sys) disable iff (sys_rst)
    (req.valid && !req.idx_from_reg)
      |=> ((rsp.result & ~$past(mask)) == ($past(req.operand) & ~$past(mask)));
  endproperty
  a_keep_others: assert property (p_keep_others) else $error("other bits changed");

endmodule : bmu_core

// >>> tb/bmu_host_model.sv
// host side: byte and flags written back from the unit
`timescale 1ns/100ps
module bmu_host_model
  import bmu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire bmu_rsp_type rsp,
  output      logic [7:0]  byte_q,
  output      logic        c_q,
  output      logic        z_q
);
  // takes the strobes one cycle late, as the core's write-back stage would
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      byte_q <= 8'h5a;
      c_q    <= 1'h0;
      z_q    <= 1'h0;
    end
    else
    begin
      if (rsp.write_en) byte_q <= rsp.result;
      if (rsp.carry_we) c_q <= rsp.carry_out;
      if (rsp.zero_we) z_q <= rsp.zero_out;
    end
  end
endmodule : bmu_host_model

// >>> tb/bit_manipulation_unit_tb_top.sv
// self-checking bench of the bit-manipulation unit
`timescale 1ns/100ps
module bit_manipulation_unit_tb_top;
  import bmu_pkg::*;
  logic        clk_sys    = 1'h0;
  logic        sys_rst    = 1'h1;
  bmu_req_type req        = '0;
  bmu_rsp_type rsp;
  logic [7:0]  m_byte;
  logic        m_c;
  logic        m_z;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          cyc        = 0;
  logic [31:0] seed       = 32'h62;
  bmu_req_type r;
  logic [7:0]  x_byte     = 8'h5a;
  logic        x_c        = 1'h0;
  logic        x_z        = 1'h0;

  always #5 clk_sys = ~clk_sys;
  bmu_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rsp(rsp));
  bmu_host_model host (.clk_sys(clk_sys), .sys_rst(sys_rst), .rsp(rsp),
                       .byte_q(m_byte), .c_q(m_c), .z_q(m_z));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // keeps only as many random bits as the request carries
  function automatic bmu_req_type rnd_req();
    logic [63:0] w;
    w = {rnd(), rnd()};
    return w[$bits(bmu_req_type)-1:0];
  endfunction : rnd_req

  function automatic bmu_rsp_type want(bmu_req_type q);
    bmu_rsp_type e;
    logic [3:0]  o;
    logic [2:0]  ix;
    logic        b;
    e = '0;
    o = q.op;
    ix = q.idx_from_reg ? q.idx_reg[2:0] : q.imm_idx;
    b = q.operand[ix];
    e.done = 1'h1;
    e.result = q.operand;
    e.illegal = (o > 4'hd) || (o[0] && o > 4'h4 && q.idx_from_reg);
    if (e.illegal) return e;
    case (o)
      4'h0: e.result[ix] = 1'h1;
      4'h1: e.result[ix] = 1'h0;
      4'h2: e.result[ix] = ~b;
      4'h3: e.zero_out = ~b;
      4'h4: e.carry_out = q.carry_in & b;
      4'h5: e.carry_out = q.carry_in & ~b;
      4'h6: e.carry_out = q.carry_in | b;
      4'h7: e.carry_out = q.carry_in | ~b;
      4'h8: e.carry_out = q.carry_in ^ b;
      4'h9: e.carry_out = q.carry_in ^ ~b;
      4'ha: e.carry_out = b;
      4'hb: e.carry_out = ~b;
      4'hc: e.result[ix] = q.carry_in;
      default: e.result[ix] = ~q.carry_in;
    endcase
    e.write_en = o inside {4'h0, 4'h1, 4'h2, 4'hc, 4'hd};
    e.carry_we = o inside {[4'h4:4'hb]};
    e.zero_we = (o == 4'h3);
    return e;
  endfunction : want
  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // leaves valid high so back-to-back calls never assign twice in a step
  task automatic run_one(bmu_req_type q);
    bmu_rsp_type e;
    e = want(q);
    if (e.write_en) x_byte = e.result;
    if (e.carry_we) x_c = e.carry_out;
    if (e.zero_we) x_z = e.zero_out;
    req = q;
    @(negedge clk_sys);
    chk("flags", {3'h0, rsp.done, rsp.write_en, rsp.carry_we, rsp.zero_we, rsp.illegal},
        {3'h0, e.done, e.write_en, e.carry_we, e.zero_we, e.illegal});
    chk("result", rsp.result, e.result);
    if (e.carry_we) chk("carry", {7'h0, rsp.carry_out}, {7'h0, e.carry_out});
    if (e.zero_we) chk("zero", {7'h0, rsp.zero_out}, {7'h0, e.zero_out});
  endtask : run_one

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////
  // ceiling well above the roughly two hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'h0;
    @(negedge clk_sys);
    chk("reset", {3'h0, rsp.done, rsp.write_en, rsp.carry_we, rsp.zero_we, rsp.illegal}, 8'h0);
    $display("test reset done");
    // first half: immediate bit 7 vs register index bit 0 with junk upper bits
    for (int i = 0; i < 64; i++)
    begin
      r = rnd_req();
      r.valid = 1'h1;
      r.op = bmu_op_type'(i[3:0]);
      r.operand = m_byte;
      r.carry_in = m_c;
      if (i < 32)
      begin
        r.idx_from_reg = i[4];
        r.imm_idx = 3'h7;
        r.idx_reg = 8'hf8;
      end
      run_one(r);
      req.valid = 1'h0;
      @(negedge clk_sys);
      chk("idle", {7'h0, rsp.done}, 8'h0);
      chk("held byte", m_byte, x_byte);
      chk("held flags", {6'h0, m_c, m_z}, {6'h0, x_c, x_z});
    end
    $display("test serial done");
    for (int i = 0; i < 48; i++)
    begin
      r = rnd_req();
      r.valid = 1'h1;
      run_one(r);
    end
    req.valid = 1'h0;
    $display("test back to back done");
    close_out();
  end
endmodule : bit_manipulation_unit_tb_top
